// ===== design/etxfp_pkg.sv
// Purpose: Shared constants, types and helpers for the transmit frame path.
// Assumes: One byte per core_clk cycle on the PHY side; 250 MHz core clock.
// Notes:   Counts are in byte times of the PHY side, one byte per cycle.
package etxfp_pkg;

  // Register map, byte addresses on the register port
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_MAXLEN = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;

  // Configuration register fields
  localparam int CFG_FCS_PASS = 0;
  localparam int CFG_JUMBO = 1;
  localparam int CFG_MAXEN = 2;
  localparam int CFG_HALF = 3;
  localparam int CFG_GIG = 4;
  localparam int CFG_W = 5;
  localparam logic [4:0] CFG_RST = 5'h10;
  localparam logic [15:0] MAXLEN_RST = 16'h05EE;

  // Frame layout
  localparam logic [7:0] PREAMBLE = 8'h55;
  localparam logic [7:0] SFD = 8'hD5;
  localparam logic [7:0] JAM_BYTE = 8'h55;
  localparam logic [15:0] PRE_LAST = 16'h0007;
  localparam logic [15:0] MIN_BODY = 16'h003C;
  localparam logic [15:0] MIN_FRAME = 16'h0040;
  localparam logic [15:0] MAX_STD = 16'h05EE;
  localparam logic [15:0] MAX_VLAN = 16'h05F2;
  localparam logic [15:0] FCS_LEN = 16'h0004;
  localparam logic [15:0] FCS_LAST = 16'h0003;
  localparam logic [15:0] JAM_LAST = 16'h0003;
  localparam logic [15:0] IFG_LAST = 16'h000B;
  localparam logic [15:0] VLAN_POS = 16'h000C;
  localparam logic [7:0] VLAN_HI = 8'h81;
  localparam logic [7:0] VLAN_LO = 8'h00;
  localparam logic [15:0] NO_LIMIT = 16'hFFFF;

  // Half-duplex timing and the early-error wait window
  localparam logic [15:0] SLOT_SLOW = 16'h0040;
  localparam logic [15:0] SLOT_GIG = 16'h0200;
  localparam logic [2:0] RTX_WIN = 3'h6;
  localparam logic [4:0] MAX_TRY = 5'h0F;
  localparam logic [15:0] EARLY_WIN = 16'h0002;

  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_TAKE2 = 4'h1,
    S_HOLD = 4'h2,
    S_PRE = 4'h3,
    S_DATA = 4'h4,
    S_PAD = 4'h5,
    S_FCS = 4'h6,
    S_ERR = 4'h7,
    S_JAM = 4'h8,
    S_IFG = 4'h9,
    S_EWAIT = 4'hA
  } etxfp_state_type;

  typedef struct packed {
    logic [7:0] tdata;
    logic tvalid;
    logic tlast;
    logic tuser;
  } etxfp_axis_type;

  typedef struct packed {
    logic [7:0] txd;
    logic tx_en;
    logic tx_er;
  } etxfp_gmii_type;

  // Bytewise reflected CRC-32 update, LSB first as on the wire
  function automatic logic [31:0] etxfp_crc_upd(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r >> 1) ^ (((r[0] ^ d[i]) == 1'b1) ? CRC_POLY : 32'h0);
    end
    return r;
  endfunction : etxfp_crc_upd

endpackage : etxfp_pkg

// ===== design/etxfp_sync3.sv
// Purpose: Three-stage synchroniser with a filtered level and a rise pulse.
// Assumes: Inputs are asynchronous pins from the PHY.
// Notes:   A change counts only once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module etxfp_sync3 #(
  parameter int W = 2
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, rise_q;
  logic [W-1:0] lvl_d, rise_d;

  // Stage one feeds stage two only; filtering looks at two and three
  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
    rise_d = lvl_d & ~lvl_q;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
      rise_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      rise_q <= rise_d;
    end
  end

  assign level = lvl_q;
  assign rise = rise_q;
endmodule : etxfp_sync3
`default_nettype wire

// ===== design/etxfp_tx_path.sv
// Purpose: Transmit frame path of a tri-speed Ethernet MAC, user stream to PHY.
// Assumes: One PHY byte per cycle; user side on the same clock; no data buffer.
// Notes:   Frame lengths count in 16 bits, so jumbo frames stop at 65535 bytes.
`timescale 1ns/1ps
`default_nettype none
module etxfp_tx_path (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire etxfp_pkg::etxfp_axis_type s_axis,
  output logic s_axis_tready,
  output var etxfp_pkg::etxfp_gmii_type gmii_tx,
  input wire logic phy_col,
  input wire logic phy_crs,
  input wire logic pause_active,
  output logic tx_collision,
  output logic tx_retransmit,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import etxfp_pkg::*;

  etxfp_state_type st_q, st_d;
  etxfp_gmii_type g_q, g_d;
  logic [15:0] cnt_q, cnt_d, len_q, len_d, tk_q, tk_d, slot_q, slot_d;
  logic [7:0] b0_q, b0_d, b1_q, b1_d, sb;
  logic [1:0] pc_q, pc_d;
  logic [31:0] crc_q, crc_d, crc_n;
  logic [4:0] tries_q, tries_d;
  logic [2:0] rtxw_q, rtxw_d;
  logic lastin_q, lastin_d, minerr_q, minerr_d, trunc_q, trunc_d;
  logic open_q, open_d, vlan_q, vlan_d, burst_q, burst_d, ready_q, ready_d;
  logic col_q, col_d, rtx_q, rtx_d, slotrun_q, slotrun_d, bad_q, bad_d, snd;
  logic [CFG_W-1:0] cfg_q, cfg_d;
  logic [15:0] maxlen_q, maxlen_d, lim, body_lim, min_lim, slot_lim;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] phy_lvl, phy_rise;
  logic acc, fcs_pass, inwin;

  // Collision and carrier come from PHY pins, so they are synchronised
  etxfp_sync3 #(.W(2)) etxfp_sync3_inst (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .din({phy_crs, phy_col}),
    .level(phy_lvl),
    .rise(phy_rise)
  );

  assign acc = ready_q & s_axis.tvalid;
  assign fcs_pass = cfg_q[CFG_FCS_PASS];
  assign crc_n = ~crc_q;
  assign inwin = (st_q == S_PRE) || slotrun_q;
  assign slot_lim = cfg_q[CFG_GIG] ? SLOT_GIG : SLOT_SLOW;
  assign lim = cfg_q[CFG_JUMBO] ? NO_LIMIT : (cfg_q[CFG_MAXEN] ? maxlen_q :
               (vlan_q ? MAX_VLAN : MAX_STD));
  // User FCS bytes arrive in the stream, so they count toward the limit
  assign body_lim = (fcs_pass || cfg_q[CFG_JUMBO]) ? lim : lim - FCS_LEN;
  // zero fill covers the whole frame in user FCS mode, except for early-error frames, which pad to MIN_BODY and get an FCS
  assign min_lim = (fcs_pass && !minerr_q) ? MIN_FRAME : MIN_BODY;

  // Frame engine next-state logic
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    len_d = len_q;
    tk_d = tk_q;
    slot_d = slot_q;
    b0_d = b0_q;
    b1_d = b1_q;
    pc_d = pc_q;
    crc_d = crc_q;
    tries_d = tries_q;
    rtxw_d = rtxw_q;
    lastin_d = lastin_q;
    minerr_d = minerr_q;
    trunc_d = trunc_q;
    open_d = open_q;
    vlan_d = vlan_q;
    burst_d = burst_q;
    ready_d = ready_q;
    slotrun_d = slotrun_q;
    bad_d = bad_q;
    col_d = 1'b0;
    rtx_d = 1'b0;
    g_d.txd = 8'h00;
    g_d.tx_en = 1'b0;
    g_d.tx_er = 1'b0;
    snd = 1'b0;
    sb = 8'h00;
    // Slot timer; a frame that clears it counts as a success
    if (slotrun_q) begin
      if (slot_q == slot_lim - 16'h0001) begin
        slotrun_d = 1'b0;
        tries_d = 5'h00;
      end else begin
        slot_d = slot_q + 16'h0001;
      end
    end
    if (rtxw_q != 3'h0) begin
      if (s_axis.tvalid) begin
        rtxw_d = 3'h0;
      end else begin
        rtxw_d = rtxw_q - 3'h1;
        if (rtxw_q == 3'h1) begin
          tries_d = 5'h00;
        end
      end
    end
    if (acc) begin
      open_d = !s_axis.tlast;
    end
    case (st_q)
      S_IDLE: begin
        if (acc) begin
          b0_d = s_axis.tdata;
          tk_d = 16'h0001;
          pc_d = 2'h1;
          lastin_d = s_axis.tlast;
          trunc_d = 1'b0;
          minerr_d = 1'b0;
          vlan_d = 1'b0;
          if (s_axis.tuser) begin
            st_d = S_EWAIT;
            cnt_d = EARLY_WIN;
            ready_d = 1'b0;
          end else if (s_axis.tlast) begin
            st_d = S_HOLD;
            ready_d = 1'b0;
          end else begin
            st_d = S_TAKE2;
          end
        end
      end
      S_TAKE2: begin
        if (acc) begin
          b1_d = s_axis.tdata;
          tk_d = 16'h0002;
          pc_d = 2'h2;
          lastin_d = s_axis.tlast;
          ready_d = 1'b0;
          if (s_axis.tuser) begin
            st_d = S_EWAIT;
            cnt_d = EARLY_WIN;
          end else begin
            st_d = S_HOLD;
          end
        end
      end
      S_HOLD: begin
        if (!pause_active && (!cfg_q[CFG_HALF] || burst_q || !phy_lvl[1])) begin
          st_d = S_PRE;
          cnt_d = 16'h0000;
          burst_d = 1'b0;
        end
      end
      S_PRE: begin
        g_d.tx_en = 1'b1;
        g_d.txd = (cnt_q == PRE_LAST) ? SFD : PREAMBLE;
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q == PRE_LAST) begin
          crc_d = CRC_INIT;
          len_d = 16'h0000;
          slot_d = 16'h0000;
          slotrun_d = 1'b1;
          if (minerr_q) begin
            st_d = S_PAD;
          end else begin
            st_d = S_DATA;
            ready_d = !lastin_q;
          end
        end
      end
      S_DATA: begin
        snd = 1'b1;
        sb = b0_q;
        b0_d = b1_q;
        pc_d = pc_q - 2'h1;
        // tag bytes sit after the source address
        if (len_q == VLAN_POS && b0_q == VLAN_HI && b1_q == VLAN_LO && pc_q == 2'h2) begin
          vlan_d = 1'b1;
        end
        if (ready_q) begin
          if (!s_axis.tvalid) begin
            st_d = S_ERR;
            ready_d = 1'b0;
          end else begin
            b1_d = s_axis.tdata;
            pc_d = pc_q;
            tk_d = tk_q + 16'h0001;
            if (s_axis.tuser) begin
              st_d = S_ERR;
              ready_d = 1'b0;
            end else if (s_axis.tlast) begin
              lastin_d = 1'b1;
              ready_d = 1'b0;
            end else if (tk_q + 16'h0001 == body_lim) begin
              trunc_d = 1'b1;
              lastin_d = 1'b1;
              ready_d = 1'b0;
            end
          end
        end else if (pc_q == 2'h1) begin
          g_d.tx_er = trunc_q && fcs_pass;
          if (len_q + 16'h0001 < min_lim) begin
            st_d = S_PAD;
          end else if (fcs_pass) begin
            st_d = S_IFG;
            cnt_d = 16'h0000;
            ready_d = open_d;
            bad_d = trunc_q;
          end else begin
            st_d = S_FCS;
            cnt_d = 16'h0000;
          end
        end
      end
      S_PAD: begin
        snd = 1'b1;
        sb = 8'h00;
        if (len_q + 16'h0001 == min_lim) begin
          if (fcs_pass && !minerr_q) begin
            st_d = S_IFG;
            cnt_d = 16'h0000;
            ready_d = open_d;
            bad_d = 1'b0;
          end else begin
            st_d = S_FCS;
            cnt_d = 16'h0000;
          end
        end
      end
      S_FCS: begin
        g_d.tx_en = 1'b1;
        g_d.txd = crc_n[{cnt_q[1:0], 3'h0} +: 8];
        g_d.tx_er = trunc_q || minerr_q;
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q == FCS_LAST) begin
          st_d = S_IFG;
          cnt_d = 16'h0000;
          ready_d = open_d;
          bad_d = trunc_q || minerr_q;
        end
      end
      S_ERR: begin
        g_d.tx_en = 1'b1;
        g_d.tx_er = 1'b1;
        st_d = S_IFG;
        cnt_d = 16'h0000;
        ready_d = open_d;
        bad_d = 1'b1;
        slotrun_d = 1'b0;
      end
      S_JAM: begin
        g_d.tx_en = 1'b1;
        g_d.txd = JAM_BYTE;
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q == JAM_LAST) begin
          st_d = S_IFG;
          cnt_d = 16'h0000;
          ready_d = open_d;
          bad_d = 1'b1;
        end
      end
      S_IFG: begin
        // Ready stays up while the rest of an aborted frame is swallowed
        ready_d = open_d;
        if (cnt_q == 16'h0000 && s_axis.tvalid && !open_q && cfg_q[CFG_HALF] &&
            cfg_q[CFG_GIG]) begin
          burst_d = 1'b1;
        end
        if (cnt_q != IFG_LAST) begin
          cnt_d = cnt_q + 16'h0001;
        end else if (!open_q) begin // Ready drops a cycle after a swallowed last beat
          st_d = S_IDLE;
          ready_d = 1'b1;
        end
      end
      S_EWAIT: begin
        if (s_axis.tvalid) begin
          st_d = S_IDLE;
          ready_d = 1'b1;
        end else if (cnt_q == 16'h0000) begin
          minerr_d = 1'b1;
          st_d = S_HOLD;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      default: begin
        st_d = S_IDLE;
        ready_d = 1'b1;
      end
    endcase
    if (snd) begin
      g_d.tx_en = 1'b1;
      g_d.txd = sb;
      g_d.tx_er = g_d.tx_er | (minerr_q && st_q == S_PAD);
      crc_d = etxfp_crc_upd(crc_q, sb);
      len_d = len_q + 16'h0001;
    end
    if (phy_rise[0] && cfg_q[CFG_HALF] && (g_q.tx_en || slotrun_q) && st_q != S_JAM) begin
      col_d = 1'b1;
      slotrun_d = 1'b0;
      if (inwin && tries_q < MAX_TRY) begin
        rtx_d = 1'b1;
        tries_d = tries_q + 5'h01;
        rtxw_d = RTX_WIN;
      end else begin
        tries_d = 5'h00;
      end
      if (g_q.tx_en) begin
        st_d = S_JAM;
        cnt_d = 16'h0000;
        ready_d = 1'b0;
      end else begin
        st_d = S_IFG;
        cnt_d = 16'h0000;
        ready_d = open_d;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= S_IDLE;
      g_q <= '0;
      cnt_q <= 16'h0000;
      len_q <= 16'h0000;
      tk_q <= 16'h0000;
      slot_q <= 16'h0000;
      b0_q <= 8'h00;
      b1_q <= 8'h00;
      pc_q <= 2'h0;
      crc_q <= CRC_INIT;
      tries_q <= 5'h00;
      rtxw_q <= 3'h0;
      {lastin_q, minerr_q, trunc_q, open_q, vlan_q, burst_q} <= 6'h00;
      {col_q, rtx_q, slotrun_q, bad_q} <= 4'h0;
      ready_q <= 1'b1;
    end else begin
      st_q <= st_d;
      g_q <= g_d;
      cnt_q <= cnt_d;
      len_q <= len_d;
      tk_q <= tk_d;
      slot_q <= slot_d;
      b0_q <= b0_d;
      b1_q <= b1_d;
      pc_q <= pc_d;
      crc_q <= crc_d;
      tries_q <= tries_d;
      rtxw_q <= rtxw_d;
      {lastin_q, minerr_q, trunc_q, open_q, vlan_q, burst_q} <=
        {lastin_d, minerr_d, trunc_d, open_d, vlan_d, burst_d};
      {col_q, rtx_q, slotrun_q, bad_q} <= {col_d, rtx_d, slotrun_d, bad_d};
      ready_q <= ready_d;
    end
  end

  // Register port: writes take effect next cycle, reads answer next cycle
  always_comb begin
    cfg_d = cfg_q;
    maxlen_d = maxlen_q;
    rdata_d = 32'h00000000;
    if (reg_wr && reg_addr == REG_CFG) begin
      cfg_d = reg_wdata[CFG_W-1:0];
    end
    if (reg_wr && reg_addr == REG_MAXLEN) begin
      maxlen_d = reg_wdata[15:0];
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CFG: rdata_d = {27'h0000000, cfg_q};
        REG_MAXLEN: rdata_d = {16'h0000, maxlen_q};
        REG_STAT: rdata_d = {24'h000000, burst_q, bad_q, tries_q, st_q != S_IDLE};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= CFG_RST;
      maxlen_q <= MAXLEN_RST;
      rdata_q <= 32'h00000000;
    end else begin
      cfg_q <= cfg_d;
      maxlen_q <= maxlen_d;
      rdata_q <= rdata_d;
    end
  end

  assign s_axis_tready = ready_q;
  assign gmii_tx = g_q;
  assign tx_collision = col_q;
  assign tx_retransmit = rtx_q;
  assign reg_rdata = rdata_q;
endmodule : etxfp_tx_path
`default_nettype wire

// ===== testbench/etxfp_tx_path_chk.sv
// Purpose: Concurrent checks on the transmit frame path ports.
// Assumes: Config changes only while the path is idle.
// Notes:   Frame length counts PHY cycles with enable high, preamble included.
`timescale 1ns/1ps
`default_nettype none
module etxfp_tx_path_chk (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire etxfp_pkg::etxfp_axis_type s_axis,
  input wire logic s_axis_tready,
  input wire etxfp_pkg::etxfp_gmii_type gmii_tx,
  input wire logic tx_collision,
  input wire logic tx_retransmit,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr
);
  import etxfp_pkg::*;
  logic [15:0] len_q, len_d;
  logic er_q, er_d, hi_q, hi_d, tag_q, tag_d;
  logic [4:0] cfg_q, cfg_d;

  // Running frame length and error mark; config mirrored from register writes
  always_comb begin
    len_d = gmii_tx.tx_en ? len_q + 16'h0001 : 16'h0000;
    er_d = gmii_tx.tx_en & (er_q | gmii_tx.tx_er);
    // Tag type bytes sit at PHY positions 20 and 21, after preamble and addresses
    hi_d = (gmii_tx.tx_en && len_q == 16'h0014) ? (gmii_tx.txd == VLAN_HI) :
           (hi_q & gmii_tx.tx_en);
    tag_d = gmii_tx.tx_en & (tag_q | (hi_q && len_q == 16'h0015 && gmii_tx.txd == VLAN_LO));
    cfg_d = (reg_wr && reg_addr == REG_CFG) ? reg_wdata[4:0] : cfg_q;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      len_q <= 16'h0000;
      er_q <= 1'b0;
      hi_q <= 1'b0;
      tag_q <= 1'b0;
      cfg_q <= CFG_RST;
    end else begin
      len_q <= len_d;
      er_q <= er_d;
      hi_q <= hi_d;
      tag_q <= tag_d;
      cfg_q <= cfg_d;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Aborting beats may keep ready up for a replacement frame, so they are left out
  last_drop_a: assert property (
    s_axis.tvalid && s_axis_tready && s_axis.tlast && !s_axis.tuser |=> !s_axis_tready)
    else $error("ready stayed high after the last beat");
  gap_idle_a: assert property ($fell(gmii_tx.tx_en) |-> !gmii_tx.tx_en [*8])
    else $error("frame started inside the gap");
  pre_shape_a: assert property (
    $rose(gmii_tx.tx_en) && !gmii_tx.tx_er |-> (gmii_tx.txd == PREAMBLE) [*7] ##1
    gmii_tx.txd == SFD)
    else $error("bad preamble");
  pre_hold_a: assert property (
    $rose(gmii_tx.tx_en) && !gmii_tx.tx_er |-> !s_axis_tready)
    else $error("ready high at frame start");
  rtx_col_a: assert property (tx_retransmit |-> tx_collision)
    else $error("retransmit without collision");
  col_pulse_a: assert property (tx_collision |=> !tx_collision)
    else $error("collision pulse too long");
  col_half_a: assert property (tx_collision |-> cfg_q[CFG_HALF])
    else $error("collision in full duplex");
  min_len_a: assert property (
    $fell(gmii_tx.tx_en) && !er_q && !cfg_q[CFG_HALF] |-> len_q >= 16'h0048)
    else $error("clean frame below minimum");
  max_len_a: assert property (
    $fell(gmii_tx.tx_en) && !cfg_q[CFG_JUMBO] && !cfg_q[CFG_MAXEN] |->
    len_q <= 16'h05FA && (len_q <= 16'h05F6 || er_q || tag_q))
    else $error("oversize frame not cut");

  cover property (tx_retransmit);
  cover property ($fell(gmii_tx.tx_en) && er_q);
  cover property ($fell(gmii_tx.tx_en) && len_q > 16'h05FA);
endmodule : etxfp_tx_path_chk

bind etxfp_tx_path etxfp_tx_path_chk etxfp_tx_path_chk_inst (.core_clk, .rst_b, .s_axis,
  .s_axis_tready, .gmii_tx, .tx_collision, .tx_retransmit, .reg_addr, .reg_wdata, .reg_wr);
`default_nettype wire

// ===== testbench/etxfp_src_model.sv
// Purpose: User-side frame source feeding the transmit path.
// Assumes: Ready is a registered level sampled at the rising edge.
// Notes:   Released data lines show inverted data, never a stale byte.
`timescale 1ns/1ps
`default_nettype none
module etxfp_src_model (
  input wire logic core_clk,
  input wire logic s_axis_tready,
  output var etxfp_pkg::etxfp_axis_type s_axis
);
  import etxfp_pkg::*;
  logic [7:0] seed = 8'h00;
  logic vlan = 1'b0;
  logic abort_req = 1'b0;

  initial s_axis = '0;

  // Last on final byte, tag bytes in stream
  task automatic send(input int n, input int err_at, input int gap_at, input bit hold);
    int i;
    logic [7:0] b;
    b = seed;
    for (i = 0; i < n; i++) begin
      b = i[7:0] ^ seed;
      if (vlan && i == 12) b = VLAN_HI;
      if (vlan && i == 13) b = VLAN_LO;
      if (i == gap_at) begin
        s_axis <= '{~b, 1'b0, 1'b0, 1'b0};
        @(posedge core_clk);
      end
      s_axis <= '{b, 1'b1, i == n - 1 || i == err_at || abort_req, i == err_at || abort_req};
      @(posedge core_clk);
      while (s_axis_tready !== 1'b1) @(posedge core_clk);
      if (s_axis.tuser) break;
    end
    if (!hold) s_axis <= '{~b, 1'b0, 1'b0, 1'b0};
  endtask : send
endmodule : etxfp_src_model
`default_nettype wire

// ===== testbench/etxfp_tx_path_test.sv
// Purpose: Self-checking bench for the transmit frame path.
// Assumes: Carrier pin idle; one byte per clock on the PHY side.
// Notes:   Frame lengths seen at the PHY include 8 preamble bytes.
`timescale 1ns/1ps
`default_nettype none
module etxfp_tx_path_test;
  import etxfp_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  etxfp_axis_type s_axis;
  etxfp_gmii_type gmii_tx;
  logic s_axis_tready, tx_collision, tx_retransmit;
  logic phy_col = 1'b0;
  logic pause_active = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  int err_count = 0, tests_run = 0;
  int nfr = 0, cur_len = 0, last_len = 0, last_gap = 0, idle = 0;
  logic cur_er = 1'b0, last_er = 1'b0, col_seen = 1'b0, rtx_seen = 1'b0;
  logic [7:0] fb [0:2047];

  etxfp_src_model etxfp_src_model_inst (.core_clk, .s_axis_tready, .s_axis);
  etxfp_tx_path etxfp_tx_path_inst (.core_clk, .rst_b, .s_axis, .s_axis_tready, .gmii_tx,
    .phy_col, .phy_crs(1'b0), .pause_active, .tx_collision, .tx_retransmit, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

  initial forever #2 core_clk = ~core_clk;

  // Frame capture at the PHY side; a collision makes the source abort its frame
  always @(posedge core_clk) begin
    if (gmii_tx.tx_en === 1'b1) begin
      if (cur_len == 0) last_gap <= idle;
      if (cur_len < 2048) fb[cur_len] <= gmii_tx.txd;
      cur_len <= cur_len + 1;
      cur_er <= cur_er | gmii_tx.tx_er;
    end else begin
      idle <= idle + 1;
      if (cur_len != 0) begin
        last_len <= cur_len;
        last_er <= cur_er;
        nfr <= nfr + 1;
        cur_len <= 0;
        cur_er <= 1'b0;
        idle <= 1;
      end
    end
    if (tx_collision === 1'b1) begin
      col_seen <= 1'b1;
      rtx_seen <= tx_retransmit;
      etxfp_src_model_inst.abort_req <= 1'b1;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task reg_wr_t(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // One idle edge, so a following write never re-raises the strobe in this step
    @(posedge core_clk);
  endtask : reg_wr_t

  task reg_chk(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    chk(reg_rdata, exp, "register read");
  endtask : reg_chk

  task snd(input int n, input int e, input int g, input bit h);
    etxfp_src_model_inst.send(n, e, g, h);
  endtask : snd

  // Bounded wait, since a lost frame must not hang the run
  task wait_fr(input int k);
    for (int t = 0; t < 4000 && nfr < k; t++) @(posedge core_clk);
    chk({31'h0, nfr >= k}, 32'h1, "frame seen");
  endtask : wait_fr

  task frm(input int n, input int e, input int g, input int len, input logic er);
    int k;
    k = nfr + 1;
    snd(n, e, g, 1'b0);
    wait_fr(k);
    if (len > 0) chk(32'(last_len), 32'(len), "frame length");
    chk({31'h0, last_er}, {31'h0, er}, "error mark");
  endtask : frm

  task lenc(input logic [7:0] c, input int n, input logic v, input int len, input logic er);
    reg_wr_t(REG_CFG, {24'h0, c});
    etxfp_src_model_inst.vlan = v;
    frm(n, -1, -1, len, er);
  endtask : lenc

  task t_pad;
    logic [7:0] z;
    z = 8'h00;
    frm(10, -1, -1, 72, 1'b0);
    chk({24'h0, fb[8]}, 32'h0, "first address byte");
    for (int j = 18; j < 68; j++) z = z | fb[j];
    chk({24'h0, z}, 32'h0, "pad bytes");
  endtask : t_pad

  task t_b2b;
    int k;
    k = nfr + 2;
    snd(100, -1, -1, 1'b1);
    snd(100, -1, -1, 1'b0);
    wait_fr(k);
    chk(32'(last_len), 32'h70, "second frame length");
    chk({31'h0, last_gap >= 12}, 32'h1, "gap length");
  endtask : t_b2b

  task t_pause;
    int k;
    k = nfr;
    pause_active <= 1'b1;
    fork
      snd(50, -1, -1, 1'b0);
    join_none
    repeat (100) @(posedge core_clk);
    chk(32'(nfr), 32'(k), "held while paused");
    pause_active <= 1'b0;
    wait_fr(k + 1);
  endtask : t_pause

  task col_run(input int dly, input logic rtx);
    int k;
    k = nfr + 1 + int'(rtx);
    col_seen = 1'b0;
    fork
      begin
        wait (gmii_tx.tx_en === 1'b1);
        repeat (dly) @(posedge core_clk);
        phy_col <= 1'b1;
        repeat (4) @(posedge core_clk);
        phy_col <= 1'b0;
      end
    join_none
    snd(rtx ? 300 : 1000, -1, -1, rtx);
    etxfp_src_model_inst.abort_req = 1'b0;
    if (rtx) snd(300, -1, -1, 1'b0);
    wait_fr(k);
    chk({31'h0, col_seen}, 32'h1, "collision flag");
    chk({31'h0, rtx_seen}, {31'h0, rtx}, "retransmit flag");
    if (rtx) chk(32'(last_len), 32'h138, "resent frame length");
  endtask : col_run

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // Watchdog at 50k cycles, well above the roughly 8k the sequence needs
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    reg_chk(REG_CFG, {27'h0, CFG_RST});
    reg_chk(REG_MAXLEN, {16'h0, MAXLEN_RST});
    reg_chk(8'hFC, 32'h0);
    reg_wr_t(8'hFC, 32'h1F);
    reg_wr_t(REG_MAXLEN, 32'h64);
    reg_chk(REG_MAXLEN, 32'h64);
    reg_chk(REG_CFG, 32'h10);
    t_pad();
    reg_wr_t(REG_CFG, 32'h11);
    frm(20, -1, -1, 72, 1'b0);
    frm(64, -1, -1, 72, 1'b0);
    reg_wr_t(REG_CFG, 32'h10);
    frm(100, 40, -1, 0, 1'b1);
    frm(100, -1, 30, 0, 1'b1);
    etxfp_src_model_inst.seed = 8'h40;
    snd(2, 1, -1, 1'b1);
    etxfp_src_model_inst.seed = 8'h11;
    frm(20, -1, -1, 72, 1'b0);
    chk({24'h0, fb[8]}, 32'h11, "replacement frame sent");
    frm(2, 1, -1, 72, 1'b1);
    t_b2b();
    t_pause();
    lenc(8'h10, 1600, 1'b0, 1526, 1'b1);
    lenc(8'h10, 1518, 1'b1, 1530, 1'b0);
    lenc(8'h12, 1600, 1'b0, 1612, 1'b0);
    lenc(8'h14, 200, 1'b0, 0, 1'b1);
    lenc(8'h16, 200, 1'b0, 212, 1'b0);
    etxfp_src_model_inst.vlan = 1'b0;
    reg_wr_t(REG_CFG, 32'h18);
    col_run(30, 1'b1);
    col_run(560, 1'b0);
    report_and_stop();
  end
endmodule : etxfp_tx_path_test
`default_nettype wire
